// [core/trs_defs.svh]
// timing constants for the three rail sequencer
`ifndef TRS_DEFS_SVH
`define TRS_DEFS_SVH
`define TRS_CLK_MHZ        250
`define TRS_MS_CYCLES      (`TRS_CLK_MHZ * 1000)
`define TRS_REFRESH_US     400
`define TRS_REFRESH_CYCLES (`TRS_REFRESH_US * `TRS_CLK_MHZ)
`define TRS_SETTLE_MS      120
`define TRS_SETTLE_CYCLES  (`TRS_SETTLE_MS * `TRS_MS_CYCLES)
`define TRS_OPT_10MS_MS    10
`define TRS_OPT_30MS_MS    30
`define TRS_OPT_60MS_MS    60
`define TRS_OPT_120MS_MS   120
`define TRS_OPT_2MS_MS     2
`define TRS_OPT_16MS_MS    16
`define TRS_TMR_W          32
`endif

// [core/trs_pkg.sv]
// types for the three rail sequencer
package trs_pkg;
  typedef enum logic [2:0] {
    timing_option_10ms,
    timing_option_30ms,
    timing_option_60ms,
    timing_option_120ms,
    timing_option_2ms,
    timing_option_16ms
  } trs_timing_e;

  typedef enum logic [2:0] {
    TRS_ST_OFF,
    TRS_ST_UP,
    TRS_ST_ON,
    TRS_ST_DOWN,
    TRS_ST_SETTLE
  } trs_state_e;
endpackage

// [core/trs_sequencer.sv]
// three rail power sequencing state machine
// Functional notes
// - after reset all outputs low, no timer runs until enable first rises
// - enable high: delay 1, release 1, delay 2, release 2, delay 3, release 3
// - enable drops before output 1 released: timer cleared, outputs stay low
// - enable low: power-down delay, then drop rails one by one after delays
// - three power-down delays programmable separately from power-up delays
// - enable drop after first delay mid power-up gives a controlled shutdown
// - falling edge restarts running timer; power-up finishes before power-down
// - after forced power-up completion wait 120 ms before power-down
// - enable rise mid power-down, after first delay, finishes power-down first
// - rising edge restarts running timer; remaining rails drop in programmed order
// - after forced power-down completion wait 120 ms before power-up
// - all six delays derive from the one system clock
// - first up and first down delays lengthened by 400 us refresh time
// - option 1: up order 1-2-3, down order 3-2-1
// - up order fixed; options 1..6 pick down orders 321,312,231,213,132,123
`timescale 1ns/1ps
`include "trs_defs.svh"
module trs_sequencer
  import trs_pkg::*;
#(
  parameter int          TW           = `TRS_TMR_W,
  parameter logic [2:0]  SEQ_OPTION   = 3'h1,
  parameter trs_timing_e TIMING       = timing_option_10ms,
  // per-delay overrides in cycles; zero selects the timing option value
  parameter int          UP_CYC_1     = 0,
  parameter int          UP_CYC_2     = 0,
  parameter int          UP_CYC_3     = 0,
  parameter int          DN_CYC_1     = 0,
  parameter int          DN_CYC_2     = 0,
  parameter int          DN_CYC_3     = 0,
  parameter int          REFRESH_CYC  = `TRS_REFRESH_CYCLES,
  parameter int          SETTLE_CYC   = `TRS_SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // enable pin, asynchronous
  input  wire logic enable_in,
  // open-drain release outputs
  input  wire logic rail_release_in_1,
  output logic      rail_release_out_1,
  output logic      rail_release_oe_1,
  input  wire logic rail_release_in_2,
  output logic      rail_release_out_2,
  output logic      rail_release_oe_2,
  input  wire logic rail_release_in_3,
  output logic      rail_release_out_3,
  output logic      rail_release_oe_3,
  // status
  output logic [2:0] rail_released
);
  // option delay in cycles, shared by all six delays of the one timer
  function automatic logic [TW-1:0] opt_cycles(trs_timing_e t);
    int ms;
    ms = `TRS_OPT_10MS_MS;
    case (t)
      timing_option_30ms:  ms = `TRS_OPT_30MS_MS;
      timing_option_60ms:  ms = `TRS_OPT_60MS_MS;
      timing_option_120ms: ms = `TRS_OPT_120MS_MS;
      timing_option_2ms:   ms = `TRS_OPT_2MS_MS;
      timing_option_16ms:  ms = `TRS_OPT_16MS_MS;
      default:             ms = `TRS_OPT_10MS_MS;
    endcase
    return TW'(ms * `TRS_MS_CYCLES);
  endfunction

  function automatic logic [TW-1:0] pick(int ovr);
    return (ovr != 0) ? TW'(ovr) : opt_cycles(TIMING);
  endfunction

  // rail index (0..2) dropped at power-down step s
  function automatic logic [1:0] dn_rail(logic [2:0] opt, logic [1:0] s);
    logic [5:0] ord;
    case (opt)
      3'h2:    ord = {2'd1, 2'd0, 2'd2};
      3'h3:    ord = {2'd0, 2'd2, 2'd1};
      3'h4:    ord = {2'd2, 2'd0, 2'd1};
      3'h5:    ord = {2'd1, 2'd2, 2'd0};
      3'h6:    ord = {2'd2, 2'd1, 2'd0};
      default: ord = {2'd0, 2'd1, 2'd2};
    endcase
    return ord[2*s +: 2];
  endfunction

  localparam logic [TW-1:0] UP1 = pick(UP_CYC_1) + TW'(REFRESH_CYC);
  localparam logic [TW-1:0] UP2 = pick(UP_CYC_2);
  localparam logic [TW-1:0] UP3 = pick(UP_CYC_3);
  localparam logic [TW-1:0] DN1 = pick(DN_CYC_1) + TW'(REFRESH_CYC);
  localparam logic [TW-1:0] DN2 = pick(DN_CYC_2);
  localparam logic [TW-1:0] DN3 = pick(DN_CYC_3);
  localparam logic [TW-1:0] SET = TW'(SETTLE_CYC);

  // enable synchroniser; first stage read only by the second
  logic en_m_q, en_s_q, en_d_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      en_m_q <= 1'b0;
      en_s_q <= 1'b0;
      en_d_q <= 1'b0;
    end else begin
      en_m_q <= enable_in;
      en_s_q <= en_m_q;
      en_d_q <= en_s_q;
    end
  end
  wire en_rise = en_s_q & ~en_d_q;
  wire en_fall = ~en_s_q & en_d_q;

  trs_state_e  st_q;
  logic [1:0]  step_q;      // sequence step 0..2
  logic        forced_q;    // opposite sequence pending after settle
  logic [2:0]  rel_q;
  logic        t_load, t_clear, t_exp;
  logic [TW-1:0] t_val;

  trs_timer #(.W(TW)) u_timer (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .load     (t_load),
    .load_val (t_val),
    .clear    (t_clear),
    .expired  (t_exp)
  );

  function automatic logic [TW-1:0] up_delay(logic [1:0] s);
    return (s == 2'd0) ? UP1 : (s == 2'd1) ? UP2 : UP3;
  endfunction
  function automatic logic [TW-1:0] dn_delay(logic [1:0] s);
    return (s == 2'd0) ? DN1 : (s == 2'd1) ? DN2 : DN3;
  endfunction

  // timer control derived from state and enable edges
  always_comb begin
    t_load  = 1'b0;
    t_clear = 1'b0;
    t_val   = '0;
    case (st_q)
      TRS_ST_OFF: begin
        if (en_rise) begin
          t_load = 1'b1;
          t_val  = UP1;
        end
      end
      // an expiry wins over a restart: the next delay starts fresh at that edge anyway
      TRS_ST_UP: begin
        if (en_fall && step_q == 2'd0) begin
          t_clear = 1'b1;
        end else if (t_exp && step_q != 2'd2) begin
          t_load = 1'b1;
          t_val  = up_delay(step_q + 2'd1);
        end else if (t_exp && (forced_q || !en_s_q)) begin
          t_load = 1'b1;
          t_val  = SET;
        end else if (en_fall) begin
          t_load = 1'b1;
          t_val  = up_delay(step_q);
        end
      end
      TRS_ST_ON: begin
        if (en_fall) begin
          t_load = 1'b1;
          t_val  = DN1;
        end
      end
      TRS_ST_DOWN: begin
        if (en_rise && step_q == 2'd0) begin
          t_clear = 1'b1;
        end else if (t_exp && step_q != 2'd2) begin
          t_load = 1'b1;
          t_val  = dn_delay(step_q + 2'd1);
        end else if (t_exp && (forced_q || en_s_q)) begin
          t_load = 1'b1;
          t_val  = SET;
        end else if (en_rise) begin
          t_load = 1'b1;
          t_val  = dn_delay(step_q);
        end
      end
      TRS_ST_SETTLE: begin
        if (t_exp) begin
          t_load = 1'b1;
          t_val  = (rel_q == 3'b111) ? DN1 : UP1;
        end
      end
      default: ;
    endcase
  end

  // sequence state; while a forced run completes only further enable edges in the forcing direction are looked at, to restart the delay
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q     <= TRS_ST_OFF;
      step_q   <= 2'd0;
      forced_q <= 1'b0;
      rel_q    <= 3'b000;
    end else begin
      case (st_q)
        TRS_ST_OFF: begin
          if (en_rise) begin
            st_q   <= TRS_ST_UP;
            step_q <= 2'd0;
          end
        end
        TRS_ST_UP: begin
          if (en_fall && step_q == 2'd0) begin
            st_q <= TRS_ST_OFF;
          end else if (t_exp) begin
            rel_q[step_q] <= 1'b1;
            if (step_q != 2'd2) begin
              step_q <= step_q + 2'd1;
              if (en_fall) forced_q <= 1'b1;
            end else begin
              // a fall on the last expiry still owes the settle gap, else the rails would stay up
              st_q     <= (forced_q || !en_s_q) ? TRS_ST_SETTLE : TRS_ST_ON;
              forced_q <= 1'b0;
            end
          end else if (en_fall) begin
            forced_q <= 1'b1;
          end
        end
        TRS_ST_ON: begin
          if (en_fall) begin
            st_q   <= TRS_ST_DOWN;
            step_q <= 2'd0;
          end
        end
        TRS_ST_DOWN: begin
          if (en_rise && step_q == 2'd0) begin
            st_q <= TRS_ST_ON;
          end else if (t_exp) begin
            rel_q[dn_rail(SEQ_OPTION, step_q)] <= 1'b0;
            if (step_q != 2'd2) begin
              step_q <= step_q + 2'd1;
              if (en_rise) forced_q <= 1'b1;
            end else begin
              // a rise on the last expiry would otherwise be lost and leave the block off
              st_q     <= (forced_q || en_s_q) ? TRS_ST_SETTLE : TRS_ST_OFF;
              forced_q <= 1'b0;
            end
          end else if (en_rise) begin
            forced_q <= 1'b1;
          end
        end
        TRS_ST_SETTLE: begin
          if (t_exp) begin
            st_q   <= (rel_q == 3'b111) ? TRS_ST_DOWN : TRS_ST_UP;
            step_q <= 2'd0;
          end
        end
        default: st_q <= TRS_ST_OFF;
      endcase
    end
  end

  // open drain: drive low whenever a rail is held
  assign rail_release_out_1 = 1'b0;
  assign rail_release_out_2 = 1'b0;
  assign rail_release_out_3 = 1'b0;
  assign rail_release_oe_1  = ~rel_q[0];
  assign rail_release_oe_2  = ~rel_q[1];
  assign rail_release_oe_3  = ~rel_q[2];
  assign rail_released      = rel_q;
endmodule // trs_sequencer

// [core/trs_timer.sv]
// down counter used as the single sequence timer
`timescale 1ns/1ps
module trs_timer #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         clear,
  // status
  output logic              expired
);
  logic [W-1:0] cnt_q;
  logic         run_q;

  // counts down to one then flags expiry for a single cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (clear) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (load) begin
      cnt_q <= load_val;
      run_q <= 1'b1;
    end else if (run_q) begin
      cnt_q <= cnt_q - W'(1);
      if (cnt_q == W'(1)) run_q <= 1'b0;
    end
  end

  // not gated by load or clear: the sequencer derives load from this flag, so gating by load would close a loop
  assign expired = run_q && (cnt_q == W'(1));
endmodule // trs_timer

// [tb/tb_top.sv]
// bench for the three rail sequencer, one instance per drop order option
`timescale 1ns/1ps
module tb_top;
  import trs_pkg::*;
  localparam int SET = 60;
  // shortened delays in cycles; the step windows below are built around these
  localparam int UP_1 = 20;
  localparam int UP_2 = 30;
  localparam int UP_3 = 40;
  localparam int DN_1 = 24;
  localparam int DN_2 = 34;
  localparam int DN_3 = 44;
  localparam int REF  = 6;
  logic        clk_sys;
  logic        rst;
  logic        enable_in;
  wire  [2:0]  rr [1:6];
  logic [2:0]  prev [1:6];
  logic [11:0] ord [1:6];
  logic [11:0] exp_ord [1:6] = '{12'h321, 12'h312, 12'h231, 12'h213, 12'h132, 12'h123};
  int          n_fail = 0;
  int          samples_checked = 0;
  // six instances differ only in drop order; short delays keep the run brief
  for (genvar g = 1; g <= 6; g++) begin : g_opt
    logic [2:0] oe;
    logic [2:0] drv;
    logic [2:0] lvl;
    trs_sequencer #(.SEQ_OPTION(3'(g)), .UP_CYC_1(UP_1), .UP_CYC_2(UP_2), .UP_CYC_3(UP_3), .DN_CYC_1(DN_1),
      .DN_CYC_2(DN_2), .DN_CYC_3(DN_3), .REFRESH_CYC(REF), .SETTLE_CYC(SET)) dut (
      .clk_sys(clk_sys), .rst(rst), .enable_in(enable_in), .rail_released(rr[g]),
      .rail_release_in_1(lvl[0]), .rail_release_out_1(drv[0]), .rail_release_oe_1(oe[0]),
      .rail_release_in_2(lvl[1]), .rail_release_out_2(drv[1]), .rail_release_oe_2(oe[1]),
      .rail_release_in_3(lvl[2]), .rail_release_out_3(drv[2]), .rail_release_oe_3(oe[2]));
    trs_rail_load u_load (.oe(oe), .drv(drv), .lvl(lvl));
  end
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // log each drop per instance so the order can be judged afterwards
  always @(posedge clk_sys) begin
    for (int g = 1; g <= 6; g++) begin
      for (int b = 0; b < 3; b++) if (prev[g][b] && !rr[g][b]) ord[g] = {ord[g][7:0], 4'(b + 1)};
      prev[g] = rr[g];
    end
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic en(input logic v);
    @(posedge clk_sys);
    enable_in <= v;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // wait for the next rail change and judge how many cycles it took
  task automatic step(input int lo, input int hi, input string msg);
    logic [2:0] p;
    int         n;
    p = rr[1];
    n = 0;
    while (rr[1] === p && n < hi + 4) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check(12'(n >= lo && n <= hi), 12'h001, msg);
  endtask
  task automatic t_idle();
    idle(40);
    check(12'(rr[1]), 12'h000, "rail released without enable");
    check(12'(g_opt[1].lvl), 12'h000, "rail line not held low after reset");
  endtask
  task automatic t_glitch();
    en(1'b1);
    idle(15);
    en(1'b0);
    idle(60);
    check(12'(rr[1]), 12'h000, "short enable pulse released a rail");
  endtask
  task automatic t_up();
    en(1'b1);
    step(26, 32, "first release delay");
    check(12'(rr[1]), 12'h001, "rail 1 not first");
    step(28, 32, "second release delay");
    check(12'(rr[1]), 12'h003, "rail 2 not second");
    step(38, 42, "third release delay");
    for (int g = 1; g <= 6; g++) check(12'(rr[g]), 12'h007, "rails not all released");
    check(12'(g_opt[1].lvl), 12'h007, "rail lines not pulled up after release");
  endtask
  task automatic t_cancel();
    en(1'b0);
    idle(12);
    en(1'b1);
    idle(80);
    check(12'(rr[1]), 12'h007, "short low pulse dropped a rail");
  endtask
  task automatic t_down();
    for (int g = 1; g <= 6; g++) ord[g] = 12'h000;
    en(1'b0);
    step(30, 36, "first drop delay");
    step(32, 36, "second drop delay");
    step(42, 46, "third drop delay");
    idle(2);
    for (int g = 1; g <= 6; g++) check(ord[g], exp_ord[g], "drop order");
  endtask
  task automatic t_forced_up();
    en(1'b1);
    step(26, 32, "first release delay");
    en(1'b0);
    step(31, 35, "restarted second release");
    step(38, 42, "forced third release");
    step(SET, SET + 40, "settle before forced drop");
    step(32, 36, "second forced drop");
    step(42, 46, "third forced drop");
    check(12'(rr[1]), 12'h000, "rails left up after shutdown");
  endtask
  task automatic t_forced_down();
    t_up();
    en(1'b0);
    step(30, 36, "first drop delay");
    en(1'b1);
    step(35, 39, "restarted second drop");
    step(42, 46, "forced third drop");
    step(SET, SET + 40, "settle before forced release");
    step(28, 32, "second release after settle");
    step(38, 42, "third release after settle");
    check(12'(rr[1]), 12'h007, "rails not back up");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // enable held low through reset, as a supply monitor would
  initial begin
    rst = 1'b1;
    enable_in = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_idle();
    t_glitch();
    t_up();
    t_cancel();
    t_down();
    t_forced_up();
    t_forced_down();
    finish_test();
  end
  // the whole sequence needs about 1100 cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    finish_test();
  end
endmodule // tb_top

// [tb/trs_rail_load.sv]
// pulled-up enable lines of the three downstream regulators
`timescale 1ns/1ps
module trs_rail_load (
  // drive from the sequencer
  input  wire logic [2:0] oe,
  input  wire logic [2:0] drv,
  // wire level back to the pins and regulators
  output logic      [2:0] lvl
);
  // pull-up wins whenever nobody pulls the line low
  assign lvl = (oe & drv) | ~oe;
endmodule // trs_rail_load

// [tb/trs_seq_properties.sv]
// port-level checker for the three rail sequencer
`timescale 1ns/1ps
module trs_seq_properties (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // enable pin
  input wire logic       enable_in,
  // open-drain release pins
  input wire logic       rail_release_in_1,
  input wire logic       rail_release_out_1,
  input wire logic       rail_release_oe_1,
  input wire logic       rail_release_in_2,
  input wire logic       rail_release_out_2,
  input wire logic       rail_release_oe_2,
  input wire logic       rail_release_in_3,
  input wire logic       rail_release_out_3,
  input wire logic       rail_release_oe_3,
  // status
  input wire logic [2:0] rail_released
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [2:0] prev_q;
  logic [2:0] rise;
  logic [2:0] drop;
  logic       up_q;
  logic       dn_q;
  // edges of the rail state, kept in a register so no sampled function is needed here
  assign rise = rail_released & ~prev_q;
  assign drop = prev_q & ~rail_released;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) prev_q <= 3'h0;
    else prev_q <= rail_released;
  end
  // partial sequences in flight; a reversal inside one is the hazard being guarded
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) up_q <= 1'b0;
    else up_q <= (rail_released != 3'h7) && (rail_released != 3'h0) && (up_q || rise != 3'h0);
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) dn_q <= 1'b0;
    else dn_q <= (rail_released != 3'h7) && (rail_released != 3'h0) && (dn_q || drop != 3'h0);
  end
  a_oe_polarity: assert property (
    {rail_release_oe_3, rail_release_oe_2, rail_release_oe_1} == ~rail_released) else $error("oe not inverse of state");
  a_drive_low: assert property (
    {rail_release_out_3, rail_release_out_2, rail_release_out_1} == 3'h0) else $error("pin drive value not low");
  a_up_order: assert property (
    (rise[1] |-> rail_released[0]) and (rise[2] |-> &rail_released[1:0])) else $error("release out of order");
  a_single_step: assert property (
    $countones(rise | drop) <= 1) else $error("two rails moved at once");
  a_step_hold: assert property (
    (rise | drop) != 3'h0 |=> $stable(rail_released) [*8]) else $error("rail step too soon");
  a_no_drop_up: assert property (
    up_q |-> drop == 3'h0) else $error("drop during power-up");
  a_no_rise_down: assert property (
    dn_q |-> rise == 3'h0) else $error("release during power-down");
  a_idle_low: assert property (
    (!enable_in && rail_released == 3'h0) [*6] |=> !rise[0]) else $error("release with enable low");
  a_first_cause: assert property (
    rise[0] |-> $past(enable_in, 8)) else $error("rail 1 released without enable");
endmodule // trs_seq_properties

bind trs_sequencer trs_seq_properties u_props (
  .clk_sys(clk_sys), .rst(rst), .enable_in(enable_in), .rail_released(rail_released),
  .rail_release_in_1(rail_release_in_1), .rail_release_out_1(rail_release_out_1), .rail_release_oe_1(rail_release_oe_1),
  .rail_release_in_2(rail_release_in_2), .rail_release_out_2(rail_release_out_2), .rail_release_oe_2(rail_release_oe_2),
  .rail_release_in_3(rail_release_in_3), .rail_release_out_3(rail_release_out_3), .rail_release_oe_3(rail_release_oe_3));
